// File: code_range_pkg.sv
package code_range_pkg;

    // Stream geometry
    localparam int COMP_W = 16;
    localparam int COMP_N = 3;
    localparam int PIX_W = COMP_W * COMP_N;

    // Declared colour format
    typedef enum logic [1:0] {
        FMT_RGB = 2'h0,
        FMT_YCC444 = 2'h1,
        FMT_YCC422 = 2'h2
    } fmt_e;

    // Declared component depth code
    typedef enum logic [2:0] {
        BPC6 = 3'h0,
        BPC8 = 3'h1,
        BPC10 = 3'h2,
        BPC12 = 3'h3,
        BPC16 = 3'h4
    } bpc_e;

    // Full-range largest code per depth
    localparam logic [15:0] MAX_6 = 16'h003F;
    localparam logic [15:0] MAX_8 = 16'h00FF;
    localparam logic [15:0] MAX_10 = 16'h03FF;
    localparam logic [15:0] MAX_12 = 16'h0FFF;
    localparam logic [15:0] MAX_16 = 16'hFFFF;

    // Limited-range bounds at 8 bits; deeper depths shift them left
    localparam logic [15:0] LUMA_LO_8 = 16'h0010;
    localparam logic [15:0] LUMA_HI_8 = 16'h00EB;
    localparam logic [15:0] CHROMA_LO_8 = 16'h0010;
    localparam logic [15:0] CHROMA_HI_8 = 16'h00F0;
    localparam logic [15:0] CHROMA_ZERO_8 = 16'h0080;

    // Left shift of the 8-bit bounds per depth
    localparam logic [3:0] SH_8 = 4'h0;
    localparam logic [3:0] SH_10 = 4'h2;
    localparam logic [3:0] SH_12 = 4'h4;
    localparam logic [3:0] SH_16 = 4'h8;

    // Descriptor reset values: fall-back format
    localparam logic [1:0] RST_FMT = 2'h0;
    localparam logic [2:0] RST_BPC = 3'h0;
    localparam logic RST_LIMITED = 1'b0;

endpackage

// File: pix_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module pix_skid_buffer #(
    parameter int W = 49
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Filling side
    pix_stream_if.snk s_in,
    // Draining side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);

    logic head_v_ff, nxt_head_v;
    logic skid_v_ff, nxt_skid_v;
    logic rdy_ff, nxt_rdy;
    logic [W-1:0] head_d_ff, nxt_head_d;
    logic [W-1:0] skid_d_ff, nxt_skid_d;
    logic in_fire;
    logic out_fire;

    generate
        if (W < 1) begin : g_bad_w
            $error("pix_skid_buffer: W must be at least 1");
        end
    endgenerate

    // Two entries: head drives the output, skid catches the word taken while the head stalls
    always_comb begin
        in_fire = s_in.valid && rdy_ff;
        out_fire = head_v_ff && i_ready;
        nxt_head_v = head_v_ff;
        nxt_head_d = head_d_ff;
        nxt_skid_v = skid_v_ff;
        nxt_skid_d = skid_d_ff;
        if (!head_v_ff || out_fire) begin
            if (skid_v_ff) begin
                nxt_head_v = 1'b1;
                nxt_head_d = skid_d_ff;
                nxt_skid_v = 1'b0;
            end else begin
                nxt_head_v = in_fire;
                nxt_head_d = in_fire ? s_in.data : head_d_ff;
            end
        end else if (in_fire) begin
            nxt_skid_v = 1'b1;
            nxt_skid_d = s_in.data;
        end
        // Ready is registered so the upstream path never sees our output combinationally
        nxt_rdy = !nxt_skid_v;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            head_v_ff <= 1'b0;
            skid_v_ff <= 1'b0;
            rdy_ff <= 1'b0;
            head_d_ff <= '0;
            skid_d_ff <= '0;
        end else begin
            head_v_ff <= nxt_head_v;
            skid_v_ff <= nxt_skid_v;
            rdy_ff <= nxt_rdy;
            head_d_ff <= nxt_head_d;
            skid_d_ff <= nxt_skid_d;
        end
    end

    assign s_in.ready = rdy_ff;
    assign o_valid = head_v_ff;
    assign o_data = head_d_ff;

    // A stalled word holds still until it is taken
    a_stall_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        head_v_ff && !i_ready |=> head_v_ff && $stable(head_d_ff))
        else $error("stalled output word changed or vanished");

    // A word taken while full of one entry appears next after the head
    a_skid_order: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        head_v_ff && !i_ready && in_fire ##1 i_ready |=> head_v_ff && head_d_ff == $past(skid_d_ff))
        else $error("skid word not forwarded in order");

endmodule // pix_skid_buffer
`default_nettype wire

// File: pix_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pix_stream_if #(
    parameter int W = 49
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: pixel_code_range_limiter.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Full-range RGB spans code zero up to the largest code of the depth.
// - Limited-range RGB puts zero intensity at 16, 64, 256 or 4096 for 8, 10, 12 or 16 bits.
// - Limited-range RGB puts maximum intensity at 235, 940, 3760 or 60160 for 8, 10, 12 or 16 bits.
// - An 18 bpp RGB stream is always full range.
// - The sink limits RGB codes to the declared range itself.
// - Luma runs 16 to 235 at 8 bits, scaled by four per two extra bits.
// - Chroma zero sits at 128, 512, 2048 or 32768 and passes unchanged.
// - Chroma runs 16 to 240 at 8 bits, scaled the same way.
// - The sink restricts YCbCr codes to the range itself.
// - Format, depth and range come from the stream's descriptor only.
// - Any code may arrive in a limited stream and is clamped where needed.
module pixel_code_range_limiter #(
    parameter int COMP_W = code_range_pkg::COMP_W,
    parameter int COMP_N = code_range_pkg::COMP_N
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Stream format descriptor
    input wire logic i_desc_load,
    input wire logic [1:0] i_desc_fmt,
    input wire logic [2:0] i_desc_bpc,
    input wire logic i_desc_limited,
    // Incoming pixels, components right-aligned, component 0 is R or Y
    input wire logic i_pix_valid,
    input wire logic [COMP_W*COMP_N-1:0] i_pix_data,
    output logic o_pix_ready,
    // Outgoing clamped pixels
    output logic o_out_valid,
    output logic [COMP_W*COMP_N-1:0] o_out_data,
    output logic o_out_clamped,
    input wire logic i_out_ready,
    // Descriptor in force
    output logic [1:0] o_fmt,
    output logic [2:0] o_bpc,
    output logic o_limited
);

    localparam int PW = COMP_W * COMP_N;

    generate
        if (COMP_W != 16 || COMP_N != 3) begin : g_bad_geom
            $error("pixel_code_range_limiter: only 3 components of 16 bits are served");
        end
    endgenerate

    pix_stream_if #(.W(PW + 1)) buf_if ();

    logic [1:0] fmt_ff, nxt_fmt;
    logic [2:0] bpc_ff, nxt_bpc;
    logic lim_ff, nxt_lim;
    logic lim_eff_ff, nxt_lim_eff;
    logic [15:0] max_code;
    logic [3:0] sh;
    logic lim_eff;
    logic [COMP_N-1:0] hit;
    logic [PW-1:0] clamped;

    // Descriptor is latched on load and steers every later pixel
    always_comb begin
        nxt_fmt = fmt_ff;
        nxt_bpc = bpc_ff;
        nxt_lim = lim_ff;
        if (i_desc_load) begin
            nxt_fmt = i_desc_fmt;
            nxt_bpc = i_desc_bpc;
            nxt_lim = i_desc_limited;
        end
        // Six-bit depth has no limited coding, so the declaration is overridden before it is stored
        nxt_lim_eff = nxt_lim && (nxt_bpc != code_range_pkg::BPC6);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fmt_ff <= code_range_pkg::RST_FMT;
            bpc_ff <= code_range_pkg::RST_BPC;
            lim_ff <= code_range_pkg::RST_LIMITED;
            lim_eff_ff <= code_range_pkg::RST_LIMITED;
        end else begin
            fmt_ff <= nxt_fmt;
            bpc_ff <= nxt_bpc;
            lim_ff <= nxt_lim;
            lim_eff_ff <= nxt_lim_eff;
        end
    end

    // Depth decode; unknown depth codes fall to 8 bits rather than open the range
    always_comb begin
        unique case (code_range_pkg::bpc_e'(bpc_ff))
            code_range_pkg::BPC6: begin
                max_code = code_range_pkg::MAX_6;
                sh = code_range_pkg::SH_8;
            end
            code_range_pkg::BPC10: begin
                max_code = code_range_pkg::MAX_10;
                sh = code_range_pkg::SH_10;
            end
            code_range_pkg::BPC12: begin
                max_code = code_range_pkg::MAX_12;
                sh = code_range_pkg::SH_12;
            end
            code_range_pkg::BPC16: begin
                max_code = code_range_pkg::MAX_16;
                sh = code_range_pkg::SH_16;
            end
            default: begin
                max_code = code_range_pkg::MAX_8;
                sh = code_range_pkg::SH_8;
            end
        endcase
        // Effective range flag is kept in a flop so the status output needs no logic after it
        lim_eff = lim_eff_ff;
    end

    // Per-component clamp; the source may send any code so nothing is trusted
    genvar g;
    generate
        for (g = 0; g < COMP_N; g++) begin : g_comp
            logic [15:0] lo;
            logic [15:0] hi;
            logic [15:0] code;
            logic [15:0] res;
            logic res_hit;
            logic is_chroma;

            always_comb begin
                code = i_pix_data[g*COMP_W +: COMP_W];
                // Both 4:2:2 chroma slots share bounds, so Cb/Cr alternation needs no tracking
                is_chroma = (fmt_ff != code_range_pkg::FMT_RGB) && (g != 0);
                if (!lim_eff) begin
                    lo = 16'h0000;
                    hi = max_code;
                end else if (is_chroma) begin
                    lo = code_range_pkg::CHROMA_LO_8 << sh;
                    hi = code_range_pkg::CHROMA_HI_8 << sh;
                end else begin
                    lo = code_range_pkg::LUMA_LO_8 << sh;
                    hi = code_range_pkg::LUMA_HI_8 << sh;
                end
                // Out-of-range codes are replaced by the nearer bound
                if (code < lo) begin
                    res = lo;
                    res_hit = 1'b1;
                end else if (code > hi) begin
                    res = hi;
                    res_hit = 1'b1;
                end else begin
                    res = code;
                    res_hit = 1'b0;
                end
            end

            // Each slot drives only its own slice, so no two processes write one variable
            assign clamped[g*COMP_W +: COMP_W] = res;
            assign hit[g] = res_hit;

            a_full_max_bound: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                buf_if.valid && !lim_eff |-> buf_if.data[g*COMP_W +: COMP_W] <= max_code)
                else $error("full-range code above depth maximum");

            a_lim_low_bound: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                buf_if.valid && lim_eff && !is_chroma
                |-> buf_if.data[g*COMP_W +: COMP_W] >= (code_range_pkg::LUMA_LO_8 << sh))
                else $error("limited code below zero level");

            a_lim_high_bound: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                buf_if.valid && lim_eff && !is_chroma
                |-> buf_if.data[g*COMP_W +: COMP_W] <= (code_range_pkg::LUMA_HI_8 << sh))
                else $error("limited code above maximum level");

            a_chroma_bound: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                buf_if.valid && lim_eff && is_chroma
                |-> buf_if.data[g*COMP_W +: COMP_W] >= (code_range_pkg::CHROMA_LO_8 << sh)
                && buf_if.data[g*COMP_W +: COMP_W] <= (code_range_pkg::CHROMA_HI_8 << sh))
                else $error("chroma code outside nominal range");

            a_chroma_zero_pass: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                buf_if.valid && lim_eff && is_chroma && code == (code_range_pkg::CHROMA_ZERO_8 << sh)
                |-> buf_if.data[g*COMP_W +: COMP_W] == code)
                else $error("chroma zero level altered");

            a_inrange_pass: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                buf_if.valid && !hit[g] |-> buf_if.data[g*COMP_W +: COMP_W] == code)
                else $error("in-range code altered");

            a_clamp_to_bound: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                buf_if.valid && code > hi |-> buf_if.data[g*COMP_W +: COMP_W] == hi && hit[g])
                else $error("high code not replaced by bound");
        end
    endgenerate

    // Clamp result and its flag enter the buffer together
    assign buf_if.valid = i_pix_valid;
    assign buf_if.data = {(|hit), clamped};

    pix_skid_buffer #(.W(PW + 1)) u_buf (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .s_in(buf_if.snk),
        .o_valid(o_out_valid),
        .o_data({o_out_clamped, o_out_data}),
        .i_ready(i_out_ready)
    );

    assign o_pix_ready = buf_if.ready;
    assign o_fmt = fmt_ff;
    assign o_bpc = bpc_ff;
    assign o_limited = lim_eff_ff;

    // Six-bit depth never clamps into a limited window
    a_rgb18_full: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        bpc_ff == code_range_pkg::BPC6 |-> !o_limited)
        else $error("six-bit stream treated as limited");

    // A loaded descriptor is in force from the next cycle
    a_desc_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_desc_load |=> o_fmt == $past(i_desc_fmt) && o_bpc == $past(i_desc_bpc))
        else $error("descriptor not taken on load");

endmodule // pixel_code_range_limiter
`default_nettype wire

// File: pixel_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: sources the declared-format pixel stream, holding each word until taken
module pixel_host_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Words queued by the bench
    input wire logic i_push,
    input wire logic [47:0] i_word,
    input wire logic i_slow,
    // Pixel stream toward the sink
    output logic o_valid,
    output logic [47:0] o_data,
    input wire logic i_ready
);
    logic [47:0] fifo[$];

    // Any code may be sent whatever range is declared, so nothing is trimmed here
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_valid <= 1'b0;
            o_data <= 48'h0;
            fifo.delete();
        end else begin
            if (i_push) fifo.push_back(i_word);
            if (!o_valid || i_ready) begin
                if (fifo.size() > 0 && !(i_slow && $urandom_range(1) == 0)) begin
                    o_valid <= 1'b1;
                    o_data <= fifo.pop_front();
                end else begin
                    // Idle data scrambled so a stale word is never mistaken for a live one
                    o_valid <= 1'b0;
                    o_data <= 48'({$urandom(), $urandom()});
                end
            end
        end
    end
endmodule // pixel_host_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk, i_reset_n, i_desc_load, i_desc_limited, i_pix_valid, o_pix_ready;
    logic o_out_valid, o_out_clamped, i_out_ready, o_limited, push, slow, stall, sh_lim;
    logic [1:0] i_desc_fmt, o_fmt, sh_fmt;
    logic [2:0] i_desc_bpc, o_bpc, sh_bpc;
    logic [47:0] i_pix_data, o_out_data, word;
    logic [48:0] exp_q[$];
    logic [48:0] ex;
    int mismatches, cmp_count, n_push, n_out;
    // Codes on every depth's bounds, one step past them, and chroma zero levels
    localparam logic [15:0] CORN [32] = '{16'h0000, 16'h000F, 16'h0010, 16'h003F, 16'h0040, 16'h0080,
        16'h00EB, 16'h00EC, 16'h00F0, 16'h00F1, 16'h00FF, 16'h0100, 16'h0200, 16'h03AC, 16'h03AD,
        16'h03C0, 16'h03C1, 16'h03FF, 16'h0400, 16'h0800, 16'h0EB0, 16'h0EB1, 16'h0F00, 16'h0F01,
        16'h0FFF, 16'h1000, 16'h8000, 16'hEB00, 16'hEB01, 16'hF000, 16'hF001, 16'hFFFF};

    always #5 i_clk = ~i_clk;

    pixel_code_range_limiter i_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_desc_load(i_desc_load), .i_desc_fmt(i_desc_fmt),
        .i_desc_bpc(i_desc_bpc), .i_desc_limited(i_desc_limited), .i_pix_valid(i_pix_valid),
        .i_pix_data(i_pix_data), .o_pix_ready(o_pix_ready), .o_out_valid(o_out_valid),
        .o_out_data(o_out_data), .o_out_clamped(o_out_clamped), .i_out_ready(i_out_ready),
        .o_fmt(o_fmt), .o_bpc(o_bpc), .o_limited(o_limited));

    pixel_host_model i_host (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_push(push), .i_word(word), .i_slow(slow),
        .o_valid(i_pix_valid), .o_data(i_pix_data), .i_ready(o_pix_ready));

    // Bounds follow depth, format and range of the shadow descriptor
    function automatic logic [16:0] exp_comp(input logic [15:0] c, input int k);
        int bits, s;
        logic [15:0] lo, hi;
        bits = (sh_bpc == 3'h0) ? 6 : (sh_bpc == 3'h2) ? 10 : (sh_bpc == 3'h3) ? 12 : (sh_bpc == 3'h4) ? 16 : 8;
        s = (bits == 10) ? 2 : (bits == 12) ? 4 : (bits == 16) ? 8 : 0;
        if (sh_lim && bits != 6) begin
            lo = 16'h0010 << s;
            hi = ((sh_fmt == 2'h0 || k == 0) ? 16'h00EB : 16'h00F0) << s;
        end else begin
            lo = 16'h0000;
            hi = 16'((32'h1 << bits) - 1);
        end
        if (c < lo) return {1'b1, lo};
        if (c > hi) return {1'b1, hi};
        return {1'b0, c};
    endfunction

    function automatic logic [48:0] exp_pix(input logic [47:0] w);
        logic [48:0] r;
        logic [16:0] c;
        r = 49'h0;
        for (int k = 0; k < 3; k++) begin
            c = exp_comp(w[16*k +: 16], k);
            r[16*k +: 16] = c[15:0];
            r[48] = r[48] | c[16];
        end
        return r;
    endfunction

    task automatic check(input logic [48:0] seen, input logic [48:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Expectation is made as a pixel is taken and compared as it leaves; sink stalls at random
    always @(posedge i_clk) begin
        if (i_reset_n) begin
            if (i_pix_valid && o_pix_ready) exp_q.push_back(exp_pix(i_pix_data));
            if (o_out_valid && i_out_ready) begin
                n_out++;
                ex = (exp_q.size() > 0) ? exp_q.pop_front() : 49'bx;
                if (sh_fmt == 2'h0) check({o_out_clamped, o_out_data}, ex);
                else check({o_out_clamped, o_out_data}, ex);
            end
            i_out_ready <= stall ? 1'b0 : ($urandom_range(3) != 0);
        end
    end

    // Loads a descriptor, then scrambles the fields so only the load edge counts
    task automatic load(input logic [1:0] f, input logic [2:0] b, input logic l);
        i_desc_load <= 1'b1;
        i_desc_fmt <= f;
        i_desc_bpc <= b;
        i_desc_limited <= l;
        @(posedge i_clk);
        i_desc_load <= 1'b0;
        {i_desc_fmt, i_desc_bpc, i_desc_limited} <= 6'($urandom());
        sh_fmt = f;
        sh_bpc = b;
        sh_lim = l;
        #1;
        check({44'h0, o_fmt, o_bpc}, {44'h0, f, b});
        check({48'h0, o_limited}, {48'h0, l && (b != 3'h0)});
        @(posedge i_clk);
    endtask

    task automatic send(input logic [47:0] w);
        push <= 1'b1;
        word <= w;
        n_push++;
        @(posedge i_clk);
    endtask

    // Bounded wait for every queued word to come out
    task automatic drain();
        push <= 1'b0;
        for (int i = 0; i < 3000 && n_out != n_push; i++) @(posedge i_clk);
        if (n_out != n_push) begin
            mismatches++;
            close_out();
        end
    endtask

    initial begin
        i_clk = 1'b0;
        i_reset_n = 1'b0;
        {i_desc_load, i_desc_fmt, i_desc_bpc, i_desc_limited} = 7'h00;
        {push, slow, stall, i_out_ready, sh_lim, sh_fmt, sh_bpc} = 10'h000;
        word = 48'h0;
        mismatches = 0;
        cmp_count = 0;
        n_push = 0;
        n_out = 0;
        void'($urandom(32'h3516));
        repeat (3) @(posedge i_clk);
        #1;
        check({41'h0, o_pix_ready, o_out_valid, o_fmt, o_bpc, o_limited}, 49'h0);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        // Every format, depth and range; host alternates prompt and slow
        for (int f = 0; f < 4; f++) begin
            for (int b = 0; b < 6; b++) begin
                for (int l = 0; l < 2; l++) begin
                    load(2'(f), 3'(b), l[0]);
                    slow <= l[0];
                    foreach (CORN[i]) send({3{CORN[i]}});
                    repeat (12) send(48'({$urandom(), $urandom()}));
                    drain();
                end
            end
        end
        // Long stall: both buffer entries fill and the input must refuse
        stall <= 1'b1;
        slow <= 1'b0;
        repeat (4) send(48'h00EC_0000_FFFF);
        push <= 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        check({47'h0, o_pix_ready, o_out_valid}, 49'h1);
        stall <= 1'b0;
        drain();
        close_out();
    end
endmodule // testbench
`default_nettype wire
